// ===== rtl/hvs_cmd.sv
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "hvs_regs.svh"
module hvs_cmd import hvs_pkg::*; #(
  parameter logic [23:0] VMAX_RST = `HVS_RST_VMAX,
  parameter int          RBUF     = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output hvs_out_t         hv
);
  localparam int RW = $clog2(RBUF);
  logic        aw_q, aw_d, w_q, w_d, awr_q, awr_d, wr_q, wr_d;
  logic [7:0]  wa_q, wa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d, rmux, wm;
  logic [3:0]  ws_q, ws_d;
  logic        bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  hvs_type_t   ty_q, ty_d;
  hvs_op_t     op_q, op_d;
  hvs_st_t     st_q, st_d;
  logic        ro_q, ro_d, pol_q, pol_d, ren_q, ren_d;
  logic        ce_q, ce_d, xe_q, xe_d;
  logic [15:0] ec_q, ec_d;
  logic [23:0] vs_q, vs_d, vl_q, vl_d, ov_q, ov_d;
  logic [23:0] rp_q, rp_d, vm_q, vm_d, cap;
  logic [7:0]  t0_q, t0_d, t1_q, t1_d, up_c;
  logic [RW:0] rl_q, rl_d, rk_q, rk_d;
  logic [7:0]  rbuf_q [RBUF];
  logic        pclr, pchv, fst, fvld, fbusy, rok, bad, cer, xer, avail;
  logic [7:0]  fch;
  logic [1:0]  txn;
  logic [23:0] txt;
  hvs_val_t    fval;
  hvs_num_t    num;

  hvs_numparse u_parse (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clr      (pclr),
    .ch_vld   (pchv),
    .ch       (wd_q[7:0]),
    .comma_ok (op_q != HVS_OP_RAMP),
    .num      (num)
  );

  hvs_numfmt #(.DIGITS(8)) u_fmt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (fst),
    .val     (fval),
    .ch_vld  (fvld),
    .ch      (fch),
    .busy    (fbusy)
  );

  assign avail = rk_q < rl_q;

  always_comb begin
    rok = 1'b1;
    rmux = '0;
    case (araddr)
      `HVS_OFF_CTRL: rmux[2:0] = {ro_q, ty_q};
      `HVS_OFF_STAT: begin
        rmux[`HVS_ST_BUSY] = st_q != HVS_ST_IDLE;
        rmux[`HVS_ST_AVAIL] = avail;
        rmux[`HVS_ST_POL] = pol_q;
        rmux[`HVS_ST_REN] = ren_q;
        rmux[`HVS_ST_CERR] = ce_q;
        rmux[`HVS_ST_XERR] = xe_q;
      end
      `HVS_OFF_RESP: rmux[8:0] = {avail, rbuf_q[rk_q[RW-1:0]]};
      `HVS_OFF_ERR:  rmux[15:0] = ec_q;
      `HVS_OFF_VSET: rmux[23:0] = vs_q;
      `HVS_OFF_VLIM: rmux[23:0] = vl_q;
      `HVS_OFF_OVP:  rmux[23:0] = ov_q;
      `HVS_OFF_RAMP: rmux[23:0] = rp_q;
      `HVS_OFF_VMAX: rmux[23:0] = vm_q;
      `HVS_OFF_OPC:  rmux[3:0] = op_q;
      `HVS_OFF_CHAR: rmux = '0;
      default:       rok = 1'b0;
    endcase
  end

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    wa_d = wa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rr_d = rr_q;
    rd_d = rd_q;
    ty_d = ty_q;
    op_d = op_q;
    st_d = st_q;
    ro_d = ro_q;
    pol_d = pol_q;
    ren_d = ren_q;
    ce_d = ce_q;
    xe_d = xe_q;
    ec_d = ec_q;
    vs_d = vs_q;
    vl_d = vl_q;
    ov_d = ov_q;
    rp_d = rp_q;
    vm_d = vm_q;
    t0_d = t0_q;
    t1_d = t1_q;
    rl_d = rl_q;
    rk_d = rk_q;
    pclr = 1'b0;
    pchv = 1'b0;
    fst = 1'b0;
    fval = '0;
    txn = 2'd0;
    txt = '0;
    cer = 1'b0;
    xer = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wm[8*i +: 8] = ws_q[i] ? wd_q[8*i +: 8] : 8'h00;
    end
    up_c = (wd_q[7:0] >= 8'h61 && wd_q[7:0] <= 8'h7A) ?
           (wd_q[7:0] & 8'hDF) : wd_q[7:0];
    cap = (vl_q < vm_q) ? vl_q : vm_q;
    bad = num.err || (pol_q ? !num.minus : num.minus);
    if (awvalid && awr_q) begin
      aw_d = 1'b1;
      wa_d = awaddr;
    end
    if (wvalid && wr_q) begin
      w_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    if (aw_q && w_q && !bv_q) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = `HVS_RESP_OK;
      case (wa_q)
        `HVS_OFF_CTRL: if (ws_q[0]) begin
          ty_d = hvs_type_t'(wd_q[1:0]);
          ro_d = wd_q[`HVS_CTRL_ROPT];
          pol_d = wd_q[1:0] == HVS_T_NEG;
          ren_d = ren_q && wd_q[`HVS_CTRL_ROPT];
        end
        `HVS_OFF_CHAR: if (st_q != HVS_ST_IDLE) begin
          br_d = `HVS_RESP_ERR;
        end else if (ws_q[0] && wd_q[7:0] == `HVS_CH_LF) begin
          st_d = HVS_ST_EXEC;
        end else if (ws_q[0]) begin
          pchv = 1'b1;
          if (wd_q[7:0] != `HVS_CH_SP && wd_q[7:0] != `HVS_CH_COLON &&
              wd_q[7:0] != `HVS_CH_CR) begin
            if (t0_q == 8'h00) t0_d = up_c;
            else if (t1_q == 8'h00) t1_d = up_c;
          end
        end
        `HVS_OFF_OPC: if (st_q != HVS_ST_IDLE) begin
          br_d = `HVS_RESP_ERR;
        end else if (ws_q[0]) begin
          op_d = hvs_op_t'(wd_q[3:0]);
          pclr = 1'b1;
          t0_d = 8'h00;
          t1_d = 8'h00;
        end
        `HVS_OFF_STAT: begin
          ce_d = ce_q && !wm[`HVS_ST_CERR];
          xe_d = xe_q && !wm[`HVS_ST_XERR];
        end
        `HVS_OFF_VMAX: vm_d = wm[23:0] | (vm_q & ~{{8{ws_q[2]}},
          {8{ws_q[1]}}, {8{ws_q[0]}}});
        `HVS_OFF_RESP, `HVS_OFF_ERR, `HVS_OFF_VSET, `HVS_OFF_VLIM,
        `HVS_OFF_OVP, `HVS_OFF_RAMP: br_d = `HVS_RESP_OK;
        default: br_d = `HVS_RESP_ERR;
      endcase
    end
    if (bv_q && bready) bv_d = 1'b0;
    if (arvalid && arr_q) begin
      rv_d = 1'b1;
      rd_d = rmux;
      rr_d = rok ? `HVS_RESP_OK : `HVS_RESP_ERR;
      if (araddr == `HVS_OFF_RESP && avail) rk_d = rk_q + 1'b1;
    end
    if (rv_q && rready) rv_d = 1'b0;
    if (fvld) rl_d = rl_q + 1'b1;
    case (st_q)
      HVS_ST_EXEC: begin
        st_d = HVS_ST_IDLE;
        pclr = 1'b1;
        t0_d = 8'h00;
        t1_d = 8'h00;
        rk_d = '0;
        rl_d = '0;
        case (op_q)
          HVS_OP_VSET: begin
            if (num.err || (ty_q != HVS_T_REV &&
                num.minus != (ty_q == HVS_T_NEG))) begin
              cer = 1'b1;
            end else begin
              vs_d = (num.mag > cap) ? cap : num.mag;
              if (ty_q == HVS_T_REV) pol_d = num.minus;
            end
          end
          HVS_OP_VLIM: begin
            if (bad || num.mag > vm_q) cer = 1'b1;
            else vl_d = num.mag;
          end
          HVS_OP_OVP: begin
            if (bad || 32'(num.mag) * 100 > 32'(vm_q) * 101) begin
              cer = 1'b1;
            end else begin
              ov_d = num.mag;
            end
          end
          HVS_OP_RAMP: begin
            if (!ro_q) begin
              xer = 1'b1;
            end else if (bad || num.mag < 24'd10 ||
                         32'(num.mag) > 32'(vm_q) * 10) begin
              cer = 1'b1;
            end else begin
              rp_d = num.mag;
            end
          end
          HVS_OP_REN: begin
            if (!ro_q) begin
              xer = 1'b1;
            end else if ((t0_q == `HVS_CH_ONE && t1_q == 8'h00) ||
                         (t0_q == `HVS_CH_O && t1_q == `HVS_CH_N)) begin
              ren_d = 1'b1;
            end else if ((t0_q == `HVS_CH_ZERO && t1_q == 8'h00) ||
                         (t0_q == `HVS_CH_O && t1_q == `HVS_CH_F)) begin
              ren_d = 1'b0;
            end else begin
              cer = 1'b1;
            end
          end
          HVS_OP_POL: begin
            if (ty_q != HVS_T_REV) cer = 1'b1;
            else if (t0_q == `HVS_CH_P) pol_d = 1'b0;
            else if (t0_q == `HVS_CH_N) pol_d = 1'b1;
            else cer = 1'b1;
          end
          HVS_OP_VSETQ, HVS_OP_VLIMQ, HVS_OP_OVPQ, HVS_OP_RAMPQ: begin
            fst = 1'b1;
            st_d = HVS_ST_FMT;
            fval.neg = pol_q;
            if (op_q == HVS_OP_VSETQ) fval.mag = vs_q;
            else if (op_q == HVS_OP_VLIMQ) fval.mag = vl_q;
            else if (op_q == HVS_OP_OVPQ) fval.mag = ov_q;
            else fval.mag = ro_q ? rp_q : 24'h00_0000;
          end
          HVS_OP_RENQ: begin
            txn = 2'd1;
            txt[23:16] = (ro_q && ren_q) ? `HVS_CH_ONE : `HVS_CH_ZERO;
          end
          HVS_OP_POLQ: begin
            txn = 2'd3;
            txt = pol_q ? `HVS_TXT_NEG : `HVS_TXT_POS;
          end
          default: cer = 1'b1;
        endcase
        rl_d = (RW+1)'(txn);
      end
      HVS_ST_FMT: if (!fbusy) st_d = HVS_ST_IDLE;
      // idle keeps a line feed's request to execute
      HVS_ST_IDLE: begin
      end
      default: st_d = HVS_ST_IDLE;
    endcase
    if (cer) begin
      ce_d = 1'b1;
      ec_d = `HVS_EC_CMD;
    end
    if (xer) begin
      xe_d = 1'b1;
      ec_d = `HVS_EC_EXE;
    end
    awr_d = !aw_d && !bv_d;
    wr_d = !w_d && !bv_d;
    arr_d = !rv_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= '0;
      ws_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= `HVS_RESP_OK;
      arr_q <= 1'b0;
      rv_q <= 1'b0;
      rr_q <= `HVS_RESP_OK;
      rd_q <= '0;
      ty_q <= HVS_T_POS;
      op_q <= HVS_OP_VSETQ;
      st_q <= HVS_ST_IDLE;
      ro_q <= 1'b0;
      pol_q <= 1'b0;
      ren_q <= 1'b0;
      ce_q <= 1'b0;
      xe_q <= 1'b0;
      ec_q <= 16'h0000;
      vs_q <= 24'h00_0000;
      vl_q <= VMAX_RST;
      ov_q <= VMAX_RST;
      rp_q <= `HVS_RST_RAMP;
      vm_q <= VMAX_RST;
      t0_q <= 8'h00;
      t1_q <= 8'h00;
      rl_q <= '0;
      rk_q <= '0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awr_q <= awr_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      arr_q <= arr_d;
      rv_q <= rv_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
      ty_q <= ty_d;
      op_q <= op_d;
      st_q <= st_d;
      ro_q <= ro_d;
      pol_q <= pol_d;
      ren_q <= ren_d;
      ce_q <= ce_d;
      xe_q <= xe_d;
      ec_q <= ec_d;
      vs_q <= vs_d;
      vl_q <= vl_d;
      ov_q <= ov_d;
      rp_q <= rp_d;
      vm_q <= vm_d;
      t0_q <= t0_d;
      t1_q <= t1_d;
      rl_q <= rl_d;
      rk_q <= rk_d;
    end
  end

  // reply text store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < RBUF; i++) rbuf_q[i] <= 8'h00;
    end else if (txn != 2'd0) begin
      rbuf_q[0] <= txt[23:16];
      rbuf_q[1] <= txt[15:8];
      rbuf_q[2] <= txt[7:0];
    end else if (fvld) begin
      rbuf_q[rl_q[RW-1:0]] <= fch;
    end
  end

  assign awready = awr_q;
  assign wready = wr_q;
  assign bvalid = bv_q;
  assign bresp = br_q;
  assign arready = arr_q;
  assign rvalid = rv_q;
  assign rdata = rd_q;
  assign rresp = rr_q;
  assign hv.pol_neg = pol_q;
  assign hv.ramp_on = ren_q;
  assign hv.vset = vs_q;
  assign hv.vlim = vl_q;
  assign hv.overvoltage_threshold = ov_q;
  assign hv.ramp = rp_q;
endmodule : hvs_cmd

// ===== rtl/hvs_numfmt.sv
`timescale 1ns/1ns
`include "hvs_regs.svh"
module hvs_numfmt import hvs_pkg::*; #(
  parameter int DIGITS = 8
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  hvs_val_t        val,
  output logic            ch_vld,
  output logic [7:0]      ch,
  output logic            busy
);
  localparam int NW = $clog2(DIGITS);
  // phase: 0 idle, 1 divide, 2 sign, 3 digits, 4 point
  logic [2:0]    ph_q, ph_d;
  logic [23:0]   rem_q, rem_d;
  logic [3:0]    dig_q [DIGITS];
  logic [NW-1:0] n_q, n_d;
  logic          neg_q, neg_d;

  always_comb begin
    ph_d = ph_q;
    rem_d = rem_q;
    n_d = n_q;
    neg_d = neg_q;
    ch_vld = 1'b0;
    ch = `HVS_CH_ZERO | {4'h0, dig_q[n_q]};
    case (ph_q)
      3'd0: if (start) begin
        ph_d = 3'd1;
        rem_d = val.mag;
        n_d = '0;
        neg_d = val.neg && val.mag != '0;
      end
      3'd1: begin
        rem_d = 24'(rem_q / 10);
        if (rem_d == '0 && n_q != '0) ph_d = neg_q ? 3'd2 : 3'd3;
        else n_d = NW'(n_q + 1);
      end
      3'd2: begin
        ch_vld = 1'b1;
        ch = `HVS_CH_MINUS;
        ph_d = 3'd3;
      end
      3'd3: begin
        ch_vld = 1'b1;
        if (n_q == '0) ph_d = 3'd0;
        else if (n_q == NW'(1)) ph_d = 3'd4;
        n_d = NW'(n_q - 1);
      end
      3'd4: begin
        ch_vld = 1'b1;
        ch = `HVS_CH_DOT;
        ph_d = 3'd3;
        n_d = '0;
      end
      default: ph_d = 3'd0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_q <= 3'd0;
      rem_q <= '0;
      n_q <= '0;
      neg_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      rem_q <= rem_d;
      n_q <= n_d;
      neg_q <= neg_d;
    end
    if (ph_q == 3'd1) dig_q[n_q] <= 4'(rem_q % 10);
  end

  assign busy = ph_q != 3'd0;
endmodule : hvs_numfmt

// ===== rtl/hvs_numparse.sv
`timescale 1ns/1ns
`include "hvs_regs.svh"
module hvs_numparse import hvs_pkg::*; (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clr,
  input  wire logic       ch_vld,
  input  wire logic [7:0] ch,
  input  wire logic       comma_ok,
  output hvs_num_t        num
);
  // phase: 0 start, 1 sign, 2 int, 3 separator, 4 fraction, 5 unit
  logic [2:0]  ph_q, ph_d;
  logic [19:0] int_q, int_d;
  logic [3:0]  fr_q, fr_d;
  logic        err_q, err_d, min_q, min_d;
  logic        dig, sep;

  always_comb begin
    ph_d = ph_q;
    int_d = int_q;
    fr_d = fr_q;
    err_d = err_q;
    min_d = min_q;
    dig = (ch >= `HVS_CH_ZERO) && (ch <= 8'h39);
    sep = (ch == `HVS_CH_DOT) || (comma_ok && ch == `HVS_CH_COMMA);
    if (clr) begin
      ph_d = 3'd0;
      int_d = '0;
      fr_d = '0;
      err_d = 1'b0;
      min_d = 1'b0;
    end else if (ch_vld && ch != `HVS_CH_SP && ch != `HVS_CH_CR) begin
      if (ph_q == 3'd0 && ch == `HVS_CH_PLUS) begin
        ph_d = 3'd1;
      end else if (ph_q == 3'd0 && ch == `HVS_CH_MINUS) begin
        ph_d = 3'd1;
        min_d = 1'b1;
      end else if (dig && ph_q <= 3'd2) begin
        ph_d = 3'd2;
        if (int_q > 20'd99999) err_d = 1'b1;
        else int_d = 20'(int_q * 10 + ch[3:0]);
      end else if (dig && ph_q == 3'd3) begin
        ph_d = 3'd4;
        fr_d = ch[3:0];
      end else if (sep && ph_q == 3'd2) begin
        ph_d = 3'd3;
      end else if ((ch & 8'hDF) == `HVS_CH_V &&
                   (ph_q == 3'd2 || ph_q == 3'd4)) begin
        ph_d = 3'd5;
      end else begin
        err_d = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_q <= 3'd0;
      int_q <= '0;
      fr_q <= '0;
      err_q <= 1'b0;
      min_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      int_q <= int_d;
      fr_q <= fr_d;
      err_q <= err_d;
      min_q <= min_d;
    end
  end

  assign num.err = err_q || ph_q == 3'd0 || ph_q == 3'd1 || ph_q == 3'd3;
  assign num.minus = min_q;
  assign num.mag = 24'(int_q * 10 + fr_q);
endmodule : hvs_numparse

// ===== shared/hvs_pkg.sv
package hvs_pkg;
  typedef enum logic [1:0] {
    HVS_T_POS = 2'b00, HVS_T_NEG = 2'b01, HVS_T_REV = 2'b10
  } hvs_type_t;
  typedef enum logic [3:0] {
    HVS_OP_VSET = 4'h0, HVS_OP_VSETQ = 4'h1, HVS_OP_VLIM = 4'h2,
    HVS_OP_VLIMQ = 4'h3, HVS_OP_OVP = 4'h4, HVS_OP_OVPQ = 4'h5,
    HVS_OP_RAMP = 4'h6, HVS_OP_RAMPQ = 4'h7, HVS_OP_REN = 4'h8,
    HVS_OP_RENQ = 4'h9, HVS_OP_POL = 4'hA, HVS_OP_POLQ = 4'hB
  } hvs_op_t;
  typedef enum logic [1:0] {
    HVS_ST_IDLE = 2'b00, HVS_ST_EXEC = 2'b01, HVS_ST_FMT = 2'b10
  } hvs_st_t;
  typedef struct packed {
    logic        err;
    logic        minus;
    logic [23:0] mag;
  } hvs_num_t;
  typedef struct packed {
    logic        neg;
    logic [23:0] mag;
  } hvs_val_t;
  typedef struct packed {
    logic        pol_neg;
    logic        ramp_on;
    logic [23:0] vset;
    logic [23:0] vlim;
    logic [23:0] overvoltage_threshold;
    logic [23:0] ramp;
  } hvs_out_t;
endpackage : hvs_pkg

// ===== shared/hvs_regs.svh
`ifndef HVS_REGS_SVH
`define HVS_REGS_SVH
`define HVS_OFF_CTRL  8'h00
`define HVS_OFF_CHAR  8'h04
`define HVS_OFF_STAT  8'h08
`define HVS_OFF_RESP  8'h0C
`define HVS_OFF_ERR   8'h10
`define HVS_OFF_VSET  8'h14
`define HVS_OFF_VLIM  8'h18
`define HVS_OFF_OVP   8'h1C
`define HVS_OFF_RAMP  8'h20
`define HVS_OFF_VMAX  8'h24
`define HVS_OFF_OPC   8'h28
`define HVS_CTRL_ROPT 2
`define HVS_ST_BUSY   0
`define HVS_ST_AVAIL  1
`define HVS_ST_POL    2
`define HVS_ST_REN    3
`define HVS_ST_CERR   4
`define HVS_ST_XERR   5
`define HVS_RST_VMAX  24'h00_2710
`define HVS_RST_RAMP  24'h00_000A
`define HVS_EC_CMD    16'hFF9C
`define HVS_EC_EXE    16'hFF38
`define HVS_RESP_OK   2'h0
`define HVS_RESP_ERR  2'h2
`define HVS_CH_LF     8'h0A
`define HVS_CH_CR     8'h0D
`define HVS_CH_SP     8'h20
`define HVS_CH_COLON  8'h3A
`define HVS_CH_PLUS   8'h2B
`define HVS_CH_MINUS  8'h2D
`define HVS_CH_DOT    8'h2E
`define HVS_CH_COMMA  8'h2C
`define HVS_CH_ZERO   8'h30
`define HVS_CH_ONE    8'h31
`define HVS_CH_V      8'h56
`define HVS_CH_O      8'h4F
`define HVS_CH_N      8'h4E
`define HVS_CH_F      8'h46
`define HVS_CH_P      8'h50
`define HVS_TXT_POS   24'h50_4F53
`define HVS_TXT_NEG   24'h4E_4547
`endif

// ===== testbench/hv_voltage_setpoint_commands_tb_top.sv
`timescale 1ns/1ns
`include "hvs_regs.svh"
module hv_voltage_setpoint_commands_tb_top import hvs_pkg::*;;
  typedef struct packed {
    logic [2:0]  ctrl;
    hvs_op_t     op;
    logic [63:0] arg;
    logic [63:0] reply;
    logic [1:0]  err;
  } hvs_row_t;
  localparam int NROW = 37;
  localparam hvs_row_t ROWS [NROW] = '{
    '{3'h0, HVS_OP_POLQ, '0, "POS", 2'h0},
    '{3'h0, HVS_OP_VSET, "+200,5V", '0, 2'h0},
    '{3'h0, HVS_OP_VSETQ, '0, "200.5", 2'h0},
    '{3'h0, HVS_OP_VSET, "-5", '0, 2'h1},
    '{3'h0, HVS_OP_VLIM, "500", '0, 2'h0},
    '{3'h0, HVS_OP_VSET, "900V", '0, 2'h0},
    '{3'h0, HVS_OP_VSETQ, '0, "500.0", 2'h0},
    '{3'h0, HVS_OP_OVP, "1010", '0, 2'h0},
    '{3'h0, HVS_OP_OVP, "1010.1", '0, 2'h1},
    '{3'h0, HVS_OP_OVPQ, '0, "1010.0", 2'h0},
    '{3'h0, HVS_OP_RAMP, "5", '0, 2'h2},
    '{3'h0, HVS_OP_RAMPQ, '0, "0.0", 2'h0},
    '{3'h0, HVS_OP_REN, "ON", '0, 2'h2},
    '{3'h0, HVS_OP_RENQ, '0, "0", 2'h0},
    '{3'h4, HVS_OP_RAMP, "10000.0", '0, 2'h0},
    '{3'h4, HVS_OP_RAMPQ, '0, "10000.0", 2'h0},
    '{3'h4, HVS_OP_RAMP, "0.9", '0, 2'h1},
    '{3'h4, HVS_OP_RAMP, "20,0", '0, 2'h1},
    '{3'h4, HVS_OP_REN, "ON", '0, 2'h0},
    '{3'h4, HVS_OP_RENQ, '0, "1", 2'h0},
    '{3'h4, HVS_OP_REN, "OFF", '0, 2'h0},
    '{3'h4, HVS_OP_RENQ, '0, "0", 2'h0},
    '{3'h4, HVS_OP_REN, "1", '0, 2'h0},
    '{3'h4, HVS_OP_RENQ, '0, "1", 2'h0},
    '{3'h4, HVS_OP_REN, "0", '0, 2'h0},
    '{3'h4, HVS_OP_RENQ, '0, "0", 2'h0},
    '{3'h6, HVS_OP_POL, "NEG", '0, 2'h0},
    '{3'h6, HVS_OP_POLQ, '0, "NEG", 2'h0},
    '{3'h6, HVS_OP_VLIMQ, '0, "-500.0", 2'h0},
    '{3'h6, HVS_OP_OVPQ, '0, "-1010.0", 2'h0},
    '{3'h6, HVS_OP_RAMPQ, '0, "-10000.0", 2'h0},
    '{3'h6, HVS_OP_VSETQ, '0, "-500.0", 2'h0},
    '{3'h6, HVS_OP_VLIM, "500", '0, 2'h1},
    '{3'h6, HVS_OP_VSET, "+300", '0, 2'h0},
    '{3'h6, HVS_OP_POLQ, '0, "POS", 2'h0},
    '{3'h1, HVS_OP_VSET, "300", '0, 2'h1},
    '{3'h0, HVS_OP_POL, "NEG", '0, 2'h1}
  };
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, hang;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r, err;
  logic [63:0] rep;
  hvs_out_t    hv;
  int          n_mismatch, comparisons;

  hvs_cmd dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .hv(hv)
  );
  hvs_host_model host_u (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .hang(hang)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // opcode, argument chars, line feed, busy poll, drain reply
  task automatic run_cmd(input hvs_row_t w);
    int n;
    n = 0;
    rep = '0;
    host_u.wr(`HVS_OFF_OPC, {28'h0, w.op}, r);
    for (int i = 7; i >= 0; i--) begin
      if (w.arg[i*8+:8] != 8'h00)
        host_u.wr(`HVS_OFF_CHAR, {24'h0, w.arg[i*8+:8]}, r);
    end
    host_u.wr(`HVS_OFF_CHAR, 32'h0000_000A, r);
    d = 32'h0000_0001;
    while (d[0] !== 1'b0 && n < 200) begin
      host_u.rd(`HVS_OFF_STAT, d, r);
      n++;
    end
    err = d[5:4];
    host_u.rd(`HVS_OFF_RESP, d, r);
    while (d[8] === 1'b1 && n < 220) begin
      rep = {rep[55:0], d[7:0]};
      n++;
      host_u.rd(`HVS_OFF_RESP, d, r);
    end
    if (n >= 200) begin
      n_mismatch++;
      stop_test();
    end
    host_u.wr(`HVS_OFF_STAT, 32'h0000_0030, r);
  endtask : run_cmd

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (hang) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    aresetn = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < NROW; i++) begin
      if (i == 0 || ROWS[i].ctrl != ROWS[i-1].ctrl)
        host_u.wr(`HVS_OFF_CTRL, {29'h0, ROWS[i].ctrl}, r);
      run_cmd(ROWS[i]);
      check(rep, ROWS[i].reply);
      check({62'h0, err}, {62'h0, ROWS[i].err});
    end
    host_u.rd(8'hFC, d, r);
    check({r, d}, {`HVS_RESP_ERR, 32'h0000_0000});
    host_u.wr(8'hFC, 32'h0000_0001, r);
    check({62'h0, r}, {62'h0, `HVS_RESP_ERR});
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({hv.pol_neg, hv.vset, hv.vlim}, {15'h0, `HVS_RST_VMAX});
    check({hv.ramp_on, hv.overvoltage_threshold, hv.ramp},
          {1'b0, `HVS_RST_VMAX, `HVS_RST_RAMP});
    host_u.rd(`HVS_OFF_VLIM, d, r);
    check({32'h0, d}, {40'h0, `HVS_RST_VMAX});
    stop_test();
  end
endmodule : hv_voltage_setpoint_commands_tb_top

// ===== testbench/hvs_cmd_asserts.sv
`timescale 1ns/1ns
module hvs_cmd_asserts import hvs_pkg::*; #(
  parameter logic [23:0] VMAX_RST = 24'h00_2710,
  parameter int          RBUF     = 16
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input hvs_out_t         hv
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  sequence rd_done;
    rvalid && rready;
  endsequence
  bresp_hold_a: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("write response withdrawn");
  rdata_hold_a: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("read data withdrawn");
  write_answer_a: assert property (wr_take |=> !bvalid ##1 bvalid)
    else $error("write response not on second cycle");
  read_answer_a: assert property (rd_take |=> rvalid && !arready)
    else $error("read data not on next cycle");
  read_release_a: assert property (rd_done |=> !rvalid ##1 arready)
    else $error("read channel not reopened");
  aw_blocked_a: assert property (bvalid |-> !awready)
    else $error("write address open during response");
  vset_clamp_a: assert property ($changed(hv.vset) |-> hv.vset <= hv.vlim)
    else $error("setpoint above ceiling");
  ceiling_keep_a: assert property ($changed(hv.pol_neg) |-> $stable(hv.vlim))
    else $error("ceiling magnitude lost on reversal");
  thresh_keep_a: assert property ($changed(hv.pol_neg) |-> $stable(hv.overvoltage_threshold))
    else $error("threshold magnitude lost on reversal");
  ramp_keep_a: assert property ($changed(hv.pol_neg) |-> $stable(hv.ramp))
    else $error("ramp magnitude lost on reversal");
  ramp_floor_a: assert property ($changed(hv.ramp) |-> hv.ramp >= 24'h00_000A)
    else $error("ramp rate below floor");
endmodule : hvs_cmd_asserts

bind hvs_cmd hvs_cmd_asserts #(.VMAX_RST(VMAX_RST), .RBUF(RBUF)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready), .hv(hv)
);

// ===== testbench/hvs_host_model.sv
`timescale 1ns/1ns
module hvs_host_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready,
  output logic             hang
);
  localparam int LIM = 100;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hang} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < LIM) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        done = 1'b1;
        bready <= 1'b0;
      end
    end
    if (!done) hang <= 1'b1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    d = '0;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < LIM) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        done = 1'b1;
        rready <= 1'b0;
      end
    end
    if (!done) hang <= 1'b1;
  endtask : rd
endmodule : hvs_host_model
